// >>> logic/fid_pkg.sv
// Constants and types shared by the flash identity and reset command block.
// Assumes a 125 MHz system clock; all link pins are sampled on that clock.
package fid_pkg;

   // ==========================================================
   // Command codes
   localparam logic [7:0] OP_ID = 8'h9F;
   localparam logic [7:0] OP_IDQ = 8'hAF;
   localparam logic [7:0] OP_MD = 8'h90;
   localparam logic [7:0] OP_UID = 8'h4B;
   localparam logic [7:0] OP_PTAB = 8'h5A;
   localparam logic [7:0] OP_NOP = 8'h00;
   localparam logic [7:0] OP_ARM = 8'h66;
   localparam logic [7:0] OP_RST = 8'h99;
   localparam logic [7:0] OP_SECP = 8'h62;

   // ==========================================================
   // Frame shape
   localparam logic [5:0] SPI_OP_LAST = 6'h07;
   localparam logic [5:0] QPI_OP_LAST = 6'h01;
   localparam logic [5:0] SPI_ADDR_LAST = 6'h17;
   localparam logic [5:0] QPI_ADDR_LAST = 6'h05;
   localparam logic [5:0] DUMMY_DEF = 6'h08;
   localparam logic [5:0] PTAB_DUMMY = 6'h08;
   localparam logic [2:0] SPI_STEP_LAST = 3'h7;
   localparam logic [2:0] QPI_STEP_LAST = 3'h1;
   localparam logic [7:0] ID_LAST_IDX = 8'h02;
   localparam logic [7:0] FILL_BYTE = 8'hFF;

   // ==========================================================
   // Read parameter layout and reset value
   localparam int RP_DUMMY_LO = 3;
   localparam int RP_DUMMY_HI = 6;
   localparam logic [7:0] RP_RESET = 8'h00;

   // ==========================================================
   // Timing
   localparam int CLK_NS = 8;
   localparam int T_RST_NS = 100;
   localparam int RST_LOW_CYC = (T_RST_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] RST_LOW_LAST = 4'(RST_LOW_CYC - 1);
   localparam int T_HOLD_US = 35;
   localparam int HOLD_CYC = (T_HOLD_US * 1000 + CLK_NS - 1) / CLK_NS;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {FID_CMD, FID_ADDR, FID_DUMMY, FID_DATA,
                             FID_SKIP} fid_phase_e;

   typedef struct packed {
      logic [7:0] op;
      logic [23:0] addr;
   } fid_cmd_s;

endpackage : fid_pkg

// >>> logic/fid_core.sv
// Identity, unique number, parameter table, reset and security row guard.
// Assumes pins arrive asynchronously; config inputs are on clk.
`timescale 1ns/1ps

// ==========================================================
// Output byte FIFO
module fid_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0] wp;
   logic [AW:0] rp;

   // Full when pointers differ only in the wrap bit
   assign in_ready = (wp ^ rp) != {1'b1, {AW{1'b0}}};
   assign out_valid = wp != rp;
   assign out_data = mem[rp[AW-1:0]];

   // Write side
   always_ff @(posedge clk)
   begin
      if (in_valid && in_ready)
      begin
         mem[wp[AW-1:0]] <= in_data;
      end
   end

   // Pointers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wp <= '0;
         rp <= '0;
      end
      else if (flush)
      begin
         wp <= '0;
         rp <= '0;
      end
      else
      begin
         if (in_valid && in_ready)
            wp <= wp + 1'b1;
         if (out_valid && out_ready)
            rp <= rp + 1'b1;
      end
   end
endmodule : fid_fifo

// What this block does
// (RULE_01) ID command returns maker then type code
// (RULE_02) Output bits change on clock falling edge
// (RULE_03) ID bytes loop while chip select low
// (RULE_04) Host sends 90h, two dummies, address byte
// (RULE_05) Address bit 0 picks maker or device first
// (RULE_06) Maker and device bytes alternate until deselect
// (RULE_07) Unique read: 4Bh, address, dummies, 16 bytes
// (RULE_08) Unique number repeats while clock toggles
// (RULE_09) Low nibble starts; bits 8..4 must be zero
// (RULE_10) Table read: 5Ah, address, eight dummies, data
// (RULE_11) Four-line table read also uses eight dummies
// (RULE_12) No-operation only cancels the reset arm
// (RULE_13) Reset needs arm frame then reset frame
// (RULE_14) Software reset reloads volatile read parameters
// (RULE_15) Reset pin honoured per pin kind and mode
// (RULE_16) Reset pin low 100ns quiets the device
// (RULE_17) Host waits 35us after hardware reset
// (RULE_18) Reset during write aborts that operation
// (RULE_19) Resets leave status and function registers
// (RULE_20) Security program rejected while write busy
// (RULE_21) Security rows at middle byte 00h..30h
// (RULE_22) Locked security row cannot be programmed
module fid_core #(
   parameter logic [7:0] MAKER_CODE = 8'hA5,      // Arbitrary value
   parameter logic [7:0] DEVICE_CODE = 8'h5A,     // Arbitrary value
   parameter logic [15:0] TYPE_CODE = 16'h1234,   // Arbitrary value
   parameter int HOLD_CYCLES = fid_pkg::HOLD_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic [3:0] io_in,
   output logic [3:0] io_out,
   output logic [3:0] io_oe,
   input wire logic reset_pin_n,
   input wire logic qpi_mode,
   input wire logic quad_lines_enable,
   input wire logic pause_or_reset_select,
   input wire logic reset_pin_shared,
   input wire logic dedicated_reset_disable,
   input wire logic write_busy,
   input wire logic [3:0] security_row_lock_bit,
   input wire logic [7:0] nv_read_params,
   input wire logic rp_wr,
   input wire logic [7:0] rp_wdata,
   input wire logic [127:0] uid_value,
   output logic [7:0] read_params,
   output logic sw_reset_pulse,
   output logic hw_reset_active,
   output logic pdown_release,
   output logic op_abort,
   output logic sec_prog_start,
   output logic sec_prog_reject,
   output logic [1:0] sec_prog_row,
   output logic [7:0] sec_prog_byte
);
   // ==========================================================
   // Pin synchronisers and edge detect
   logic sck_m, sck_s, sck_d, cs_m, cs_s, cs_d, rpin_m, rpin_s;
   logic [3:0] io_m, io_s;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         {sck_m, sck_s, sck_d} <= 3'h0;
         {cs_m, cs_s, cs_d} <= 3'h7;
         {rpin_m, rpin_s} <= 2'h3;
         io_m <= 4'h0;
         io_s <= 4'h0;
      end
      else
      begin
         {sck_m, sck_s, sck_d} <= {sck, sck_m, sck_s};
         {cs_m, cs_s, cs_d} <= {cs_n, cs_m, cs_s};
         {rpin_m, rpin_s} <= {reset_pin_n, rpin_m};
         io_m <= io_in;
         io_s <= io_m;
      end
   end

   logic sck_rise, sck_fall, frame_end, ignore;
   assign sck_rise = sck_s & ~sck_d;
   assign sck_fall = ~sck_s & sck_d;
   assign frame_end = cs_s & ~cs_d;

   // ==========================================================
   // Command decode helpers
   fid_pkg::fid_phase_e phase;
   fid_pkg::fid_cmd_s cmd;
   logic [5:0] cnt, need_dummy, dummy_cfg;
   logic [7:0] in_sh, next_sh;
   logic [23:0] next_addr;
   logic op_done;

   // First phase after the opcode
   function automatic fid_pkg::fid_phase_e fid_start(input logic [7:0] op,
                                                     input logic q);
      case (op)
         fid_pkg::OP_ID: fid_start = q ? fid_pkg::FID_SKIP
                                       : fid_pkg::FID_DATA; // see RULE_01
         fid_pkg::OP_IDQ: fid_start = q ? fid_pkg::FID_DATA
                                        : fid_pkg::FID_SKIP;
         fid_pkg::OP_MD, fid_pkg::OP_UID,
         fid_pkg::OP_PTAB, fid_pkg::OP_SECP: fid_start = fid_pkg::FID_ADDR;
         default: fid_start = fid_pkg::FID_SKIP;
      endcase
   endfunction : fid_start

   // Parameter table contents; unlisted addresses read as fill
   function automatic logic [7:0] fid_ptab(input logic [7:0] a);
      case (a)
         8'h00: fid_ptab = 8'h53;
         8'h01: fid_ptab = 8'h46;
         8'h02: fid_ptab = 8'h44;
         8'h03: fid_ptab = 8'h50;
         default: fid_ptab = fid_pkg::FILL_BYTE;
      endcase
   endfunction : fid_ptab

   // Byte number idx of the answer to command c
   function automatic logic [7:0] fid_byte(input fid_pkg::fid_cmd_s c,
                                           input logic [7:0] idx,
                                           input logic [127:0] uid);
      logic [3:0] k;
      k = 4'hF - (c.addr[3:0] + idx[3:0]);
      case (c.op)
         fid_pkg::OP_ID, fid_pkg::OP_IDQ:
            if (idx == 8'h00)
               fid_byte = MAKER_CODE;          // see RULE_01
            else if (idx == 8'h01)
               fid_byte = TYPE_CODE[15:8];
            else
               fid_byte = TYPE_CODE[7:0];
         fid_pkg::OP_MD:
            fid_byte = (idx[0] ^ c.addr[0]) ? DEVICE_CODE
                                            : MAKER_CODE; // see RULE_05
         fid_pkg::OP_UID:
            if (c.addr[8:4] != 5'h00)
               fid_byte = fid_pkg::FILL_BYTE;  // see RULE_09
            else
               fid_byte = uid[{k, 3'b000} +: 8]; // see RULE_07
         fid_pkg::OP_PTAB: fid_byte = fid_ptab(c.addr[7:0] + idx);
         default: fid_byte = fid_pkg::FILL_BYTE;
      endcase
   endfunction : fid_byte

   // Shift paths and dummy length
   always_comb
   begin
      next_sh = qpi_mode ? {in_sh[3:0], io_s} : {in_sh[6:0], io_s[0]};
      next_addr = qpi_mode ? {cmd.addr[19:0], io_s}
                           : {cmd.addr[22:0], io_s[0]};
      dummy_cfg = {2'b00, read_params[fid_pkg::RP_DUMMY_HI:
                                      fid_pkg::RP_DUMMY_LO]};
      if (dummy_cfg == 6'h00)
         dummy_cfg = fid_pkg::DUMMY_DEF;
      if (cmd.op == fid_pkg::OP_UID)
         need_dummy = dummy_cfg;                // see RULE_07
      else if (cmd.op == fid_pkg::OP_PTAB)
         need_dummy = fid_pkg::PTAB_DUMMY;      // see RULE_10, RULE_11
      else
         need_dummy = 6'h00;
   end

   // ==========================================================
   // Frame sequencer, bits taken on rising clock edges
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase <= fid_pkg::FID_CMD;
         cnt <= 6'h00;
         in_sh <= 8'h00;
         cmd <= '0;
         op_done <= 1'b0;
      end
      else if (ignore || cs_s)
      begin
         phase <= fid_pkg::FID_CMD;
         cnt <= 6'h00;
         if (cs_d || ignore)
            op_done <= 1'b0;
      end
      else if (sck_rise)
      begin
         cnt <= cnt + 6'h01;
         case (phase)
            fid_pkg::FID_CMD:
            begin
               in_sh <= next_sh;
               if (cnt == (qpi_mode ? fid_pkg::QPI_OP_LAST
                                    : fid_pkg::SPI_OP_LAST))
               begin
                  cmd.op <= next_sh;
                  op_done <= 1'b1;
                  cnt <= 6'h00;
                  phase <= fid_start(next_sh, qpi_mode);
               end
            end
            fid_pkg::FID_ADDR:
            begin
               cmd.addr <= next_addr;              // see RULE_04
               if (cnt == (qpi_mode ? fid_pkg::QPI_ADDR_LAST
                                    : fid_pkg::SPI_ADDR_LAST))
               begin
                  cnt <= 6'h00;
                  phase <= (need_dummy == 6'h00) ? fid_pkg::FID_DATA
                                                 : fid_pkg::FID_DUMMY;
               end
            end
            fid_pkg::FID_DUMMY:
               if (cnt == need_dummy - 6'h01)      // see RULE_11
               begin
                  cnt <= 6'h00;
                  phase <= fid_pkg::FID_DATA;
               end
            default:
               cnt <= 6'h00;
         endcase
      end
   end

   // ==========================================================
   // Byte producer into the FIFO
   logic is_read, push, pop, f_ready, f_valid;
   logic [7:0] pidx, push_data, f_data;
   assign is_read = (phase == fid_pkg::FID_DATA) &&
                    (cmd.op != fid_pkg::OP_SECP);
   assign push = is_read && f_ready && !cs_s && !ignore;
   assign push_data = fid_byte(cmd, pidx, uid_value);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pidx <= 8'h00;
      else if (cs_s || ignore)
         pidx <= 8'h00;
      else if (push)
      begin
         if ((cmd.op == fid_pkg::OP_ID || cmd.op == fid_pkg::OP_IDQ) &&
             pidx == fid_pkg::ID_LAST_IDX)
            pidx <= 8'h00;                         // see RULE_03
         else
            pidx <= pidx + 8'h01;                  // see RULE_06, RULE_08
      end
   end

   fid_fifo #(.W(8), .D(4)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .flush(cs_s || ignore),
      .in_valid(push),
      .in_ready(f_ready),
      .in_data(push_data),
      .out_valid(f_valid),
      .out_ready(pop),
      .out_data(f_data)
   );

   // ==========================================================
   // Output shifter, changes on falling clock edges
   logic [7:0] sh;
   logic [2:0] bcnt;
   logic out_on;
   assign pop = sck_fall && is_read && bcnt == 3'h0 && !cs_s && !ignore;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sh <= 8'h00;
         bcnt <= 3'h0;
         out_on <= 1'b0;
      end
      else if (cs_s || ignore)
      begin
         bcnt <= 3'h0;
         out_on <= 1'b0;
      end
      else if (sck_fall && is_read)
      begin
         out_on <= 1'b1;
         if (bcnt == 3'h0)
         begin
            sh <= f_valid ? f_data : fid_pkg::FILL_BYTE; // see RULE_02
            bcnt <= qpi_mode ? fid_pkg::QPI_STEP_LAST
                             : fid_pkg::SPI_STEP_LAST;
         end
         else
         begin
            sh <= qpi_mode ? {sh[3:0], 4'h0} : {sh[6:0], 1'b0};
            bcnt <= bcnt - 3'h1;
         end
      end
   end

   // Pins are released during a hardware reset
   assign io_out = qpi_mode ? sh[7:4] : {2'b00, sh[7], 1'b0};
   assign io_oe = out_on ? (qpi_mode ? 4'hF : 4'h2) : 4'h0; // see RULE_16

   // ==========================================================
   // Software reset arm and reset
   logic arm, sw_go, hw_go;
   assign sw_go = frame_end && op_done && !ignore &&
                  cmd.op == fid_pkg::OP_RST && arm;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         arm <= 1'b0;
         sw_reset_pulse <= 1'b0;
      end
      else
      begin
         sw_reset_pulse <= sw_go;                  // see RULE_13
         if (ignore)
            arm <= 1'b0;
         else if (frame_end && op_done)
            arm <= cmd.op == fid_pkg::OP_ARM;      // see RULE_12, RULE_13
      end
   end

   // Volatile read parameters; freeze and sector lock live elsewhere
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         read_params <= fid_pkg::RP_RESET;
      else if (hw_reset_active)
         read_params <= fid_pkg::RP_RESET;         // see RULE_16
      else if (sw_go)
         read_params <= nv_read_params;            // see RULE_14, RULE_19
      else if (rp_wr)
         read_params <= rp_wdata;
   end

   // ==========================================================
   // Hardware reset pin filter and hold-off
   logic honour, rst_low;
   logic [3:0] low_cnt;
   logic [12:0] hold_cnt;
   assign honour = reset_pin_shared ?
                   (!qpi_mode && !quad_lines_enable && pause_or_reset_select)
                   : !dedicated_reset_disable;     // see RULE_15
   assign rst_low = !rpin_s && honour;
   assign hw_go = rst_low && low_cnt == fid_pkg::RST_LOW_LAST &&
                  !hw_reset_active;
   assign ignore = hw_reset_active || hold_cnt != 13'h0000;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         low_cnt <= 4'h0;
         hold_cnt <= 13'h0000;
         hw_reset_active <= 1'b0;
         pdown_release <= 1'b0;
      end
      else
      begin
         if (!rst_low)
            low_cnt <= 4'h0;
         else if (low_cnt != fid_pkg::RST_LOW_LAST)
            low_cnt <= low_cnt + 4'h1;
         hw_reset_active <= hw_go || (hw_reset_active && rst_low);
         pdown_release <= hw_go;                   // see RULE_16
         if (hw_reset_active)
            hold_cnt <= 13'(HOLD_CYCLES);          // see RULE_17
         else if (hold_cnt != 13'h0000)
            hold_cnt <= hold_cnt - 13'h0001;
      end
   end

   // Abort of a running write
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         op_abort <= 1'b0;
      else
         op_abort <= (hw_go || sw_go) && write_busy; // see RULE_18
   end

   // ==========================================================
   // Security row program guard, judged when the frame closes
   logic row_ok;
   assign row_ok = cmd.addr[23:16] == 8'h00 && cmd.addr[15:14] == 2'b00 &&
                   cmd.addr[11:8] == 4'h0;         // see RULE_21

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sec_prog_start <= 1'b0;
         sec_prog_reject <= 1'b0;
         sec_prog_row <= 2'b00;
         sec_prog_byte <= 8'h00;
      end
      else
      begin
         sec_prog_start <= 1'b0;
         sec_prog_reject <= 1'b0;
         if (frame_end && !ignore && cmd.op == fid_pkg::OP_SECP &&
             phase == fid_pkg::FID_DATA)
         begin
            sec_prog_row <= cmd.addr[13:12];
            sec_prog_byte <= cmd.addr[7:0];
            if (!write_busy && row_ok &&
                !security_row_lock_bit[cmd.addr[13:12]]) // see RULE_22
               sec_prog_start <= 1'b1;
            else
               sec_prog_reject <= 1'b1;            // see RULE_20
         end
      end
   end

   // ==========================================================
   // Checks
   a_out_on_fall: assert property (@(posedge clk) disable iff (!rst_n)
      $changed(sh) |-> $past(sck_fall)) // see RULE_02
      else $error("output changed away from a falling edge");
   a_md_first: assert property (@(posedge clk) disable iff (!rst_n)
      push && cmd.op == fid_pkg::OP_MD && pidx == 8'h00 |->
      push_data == (cmd.addr[0] ? DEVICE_CODE : MAKER_CODE)) // see RULE_05
      else $error("wrong first byte of maker/device answer");
   a_id_loop: assert property (@(posedge clk) disable iff (!rst_n)
      push && cmd.op == fid_pkg::OP_ID && pidx == 8'h02 |=>
      pidx == 8'h00) // see RULE_03
      else $error("identity sequence did not restart");
   a_uid_bad: assert property (@(posedge clk) disable iff (!rst_n)
      push && cmd.op == fid_pkg::OP_UID && cmd.addr[8:4] != 5'h00 |->
      push_data == fid_pkg::FILL_BYTE) // see RULE_09
      else $error("unique number sent for bad address");
   a_ptab_dummy: assert property (@(posedge clk) disable iff (!rst_n)
      sck_rise && !cs_s && !ignore && phase == fid_pkg::FID_DUMMY &&
      cmd.op == fid_pkg::OP_PTAB && cnt == 6'h07 |=>
      phase == fid_pkg::FID_DATA) // see RULE_11
      else $error("table read dummy count wrong");
   a_sw_armed: assert property (@(posedge clk) disable iff (!rst_n)
      sw_reset_pulse |-> $past(arm) && $past(cmd.op) == fid_pkg::OP_RST)
      // see RULE_13
      else $error("software reset without arm");
   a_nop_cancel: assert property (@(posedge clk) disable iff (!rst_n)
      frame_end && op_done && cmd.op == fid_pkg::OP_NOP |=> !arm)
      // see RULE_12
      else $error("no-operation left reset armed");
   a_sw_reload: assert property (@(posedge clk) disable iff (!rst_n)
      sw_go && !hw_reset_active |=> read_params == $past(nv_read_params))
      // see RULE_14
      else $error("read parameters not reloaded");
   a_hw_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(hw_reset_active) |-> $past(rst_low, 13) ##1 io_oe == 4'h0)
      // see RULE_16
      else $error("hardware reset filter or pin release wrong");
   a_sec_guard: assert property (@(posedge clk) disable iff (!rst_n)
      sec_prog_start |-> !$past(write_busy) &&
      !security_row_lock_bit[sec_prog_row]) // see RULE_20, RULE_22
      else $error("security program accepted while busy or locked");
   a_abort_busy: assert property (@(posedge clk) disable iff (!rst_n)
      op_abort |-> $past(write_busy)) // see RULE_18
      else $error("abort without running write");
endmodule : fid_core

// >>> testbench/fid_host.sv
// Host model of the flash link: frames, dummies, read-back.
// Assumes the device samples the link with a faster clock.
`timescale 1ns/1ps
module fid_host (
   output logic sck,
   output logic cs_n,
   output logic [3:0] io_in,
   input wire logic [3:0] io_out,
   input wire logic [3:0] io_oe
);
   logic [7:0] rd [4];
   logic [3:0] oe_seen;

   // Idle link: clock low, deselected
   initial
   begin
      sck = 1'b0;
      cs_n = 1'b1;
      io_in = 4'h0;
   end

   // ==========================================================
   // One frame; read bits taken late in the high phase
   task automatic frame(input logic q, input logic [7:0] op,
      input logic [23:0] ad, input int na, input int nd, input int nr);
      logic [31:0] sh;
      int w;
      int n;
      int b;
      w = q ? 4 : 1;
      sh = {op, ad << (8 * (3 - na))};
      n = (8 + 8 * na) / w;
      #2 cs_n = 1'b0; // Keep link edges off the clk edges
      for (int i = 0; i < n + nd + nr * 8 / w; i++)
      begin
         if (i < n)
            io_in = q ? sh[31:28] : {3'h0, sh[31]};
         else
            io_in = ~io_in; // Released lines hold no stale value
         sh = sh << w;
         #32 sck = 1'b1;
         #31;
         b = (i - n - nd) * w / 8;
         if (i >= n + nd)
            rd[b] = q ? {rd[b][3:0], io_out ^ ~io_oe} // Undriven reads inverted
                      : {rd[b][6:0], io_out[1] ^ ~io_oe[1]};
         oe_seen = io_oe;
         #1 sck = 1'b0;
      end
      cs_n = 1'b1;
      #100;
   endtask : frame
endmodule : fid_host

// >>> testbench/flash_id_reset_info_cmds_tb_top.sv
// Self-checking bench for identity, reset and security rows.
// Assumes fid_host drives the link; all else is driven here.
`timescale 1ns/1ps
module flash_id_reset_info_cmds_tb_top;
   typedef struct packed {
      logic q;
      logic [7:0] op;
      logic [23:0] ad;
      logic [1:0] na;
      logic [3:0] nd;
      logic [31:0] e;
      logic [3:0] oe;
   } fid_row_s;
   // Mode, opcode, address, sizes, four bytes, enables
   localparam fid_row_s ROWS [9] = '{
      '{1'h0, 8'h9F, 24'h0, 2'h0, 4'h0, 32'hA51234A5, 4'h2},
      '{1'h0, 8'h90, 24'h0, 2'h3, 4'h0, 32'hA55AA55A, 4'h2},
      '{1'h0, 8'h90, 24'h1, 2'h3, 4'h0, 32'h5AA55AA5, 4'h2},
      '{1'h0, 8'h4B, 24'hE, 2'h3, 4'h8, 32'hEEFF0011, 4'h2},
      '{1'h0, 8'h4B, 24'hFFFE03, 2'h3, 4'h8, 32'h33445566, 4'h2},
      '{1'h0, 8'h4B, 24'h10, 2'h3, 4'h8, 32'hFFFFFFFF, 4'h2},
      '{1'h0, 8'h5A, 24'h0, 2'h3, 4'h8, 32'h53464450, 4'h2},
      '{1'h1, 8'hAF, 24'h0, 2'h0, 4'h0, 32'hA51234A5, 4'hF},
      '{1'h1, 8'h5A, 24'h1, 2'h3, 4'h8, 32'h464450FF, 4'hF}};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic reset_pin_n = 1'b1;
   logic qpi_mode = 1'b0;
   logic quad_lines_enable = 1'b0;
   logic pause_or_reset_select = 1'b0;
   logic reset_pin_shared = 1'b0;
   logic dedicated_reset_disable = 1'b0;
   logic write_busy = 1'b0;
   logic [3:0] security_row_lock_bit = 4'h0;
   logic [7:0] nv_read_params = 8'h00;
   logic rp_wr = 1'b0;
   logic [7:0] rp_wdata = 8'h00;
   logic [127:0] uid_value = 128'h00112233445566778899AABBCCDDEEFF;
   logic sck, cs_n, sw_reset_pulse, hw_reset_active, pdown_release;
   logic op_abort, sec_prog_start, sec_prog_reject, clr = 1'b0;
   logic [3:0] io_in, io_out, io_oe;
   logic [7:0] read_params, sec_prog_byte;
   logic [1:0] sec_prog_row;
   logic [4:0] seen = 5'h00;
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;
   fid_row_s r;
   wire [31:0] got = {host.rd[0], host.rd[1], host.rd[2], host.rd[3]};

   fid_core #(.HOLD_CYCLES(20)) uut (.clk, .rst_n, .sck, .cs_n, .io_in,
      .io_out, .io_oe, .reset_pin_n, .qpi_mode, .quad_lines_enable,
      .pause_or_reset_select, .reset_pin_shared, .dedicated_reset_disable,
      .write_busy, .security_row_lock_bit, .nv_read_params, .rp_wr,
      .rp_wdata, .uid_value, .read_params, .sw_reset_pulse,
      .hw_reset_active, .pdown_release, .op_abort, .sec_prog_start,
      .sec_prog_reject, .sec_prog_row, .sec_prog_byte);
   fid_host host (.sck, .cs_n, .io_in, .io_out, .io_oe);

   // ==========================================================
   // Clock, pulse catcher and hang limit
   initial
      forever #4 clk = ~clk;

   // Sticky record of one-cycle pulses, timeout count
   always @(posedge clk)
   begin
      seen <= clr ? 5'h00 : seen | {sw_reset_pulse, op_abort,
         pdown_release, sec_prog_start, sec_prog_reject};
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         n_mismatch++;
         conclude();
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %0t got %h want %h", $time, g, e);
      end
   endtask : chk

   task automatic clear();
      @(posedge clk) clr <= 1'b1;
      @(posedge clk) clr <= 1'b0;
   endtask : clear

   task automatic sec(input logic [23:0] ad, input logic [3:0] lk,
      input logic bz, input logic [1:0] e);
      @(posedge clk);
      security_row_lock_bit <= lk;
      write_busy <= bz;
      clear();
      host.frame(1'b0, 8'h62, ad, 3, 0, 0);
      chk(seen[1:0], e);
   endtask : sec

   task automatic hwr(input int n, input logic [9:0] e);
      clear();
      @(posedge clk) reset_pin_n <= 1'b0;
      repeat (n) @(posedge clk);
      #1 chk(hw_reset_active, e[9]);
      @(posedge clk) reset_pin_n <= 1'b1;
      repeat (40) @(posedge clk);
      chk({seen[2], read_params}, e[8:0]);
   endtask : hwr

   task automatic conclude();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   // ==========================================================
   // Table rows, then hand-written cases
   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1 chk({io_oe, read_params, hw_reset_active}, 13'h0);
      $display("test reset done");
      foreach (ROWS[i])
      begin
         r = ROWS[i];
         @(posedge clk) qpi_mode <= r.q;
         @(posedge clk);
         host.frame(r.q, r.op, r.ad, r.na, r.nd, 4);
         chk(got[31:16], r.e[31:16]);
         chk(got[15:0], r.e[15:0]);
         chk(io_oe === 4'h0 ? host.oe_seen : 4'h0, r.oe);
         $display("test row %0d done", i);
      end
      @(posedge clk);
      qpi_mode <= 1'b0;
      nv_read_params <= 8'h48;
      rp_wdata <= 8'h28;
      rp_wr <= 1'b1;
      @(posedge clk) rp_wr <= 1'b0;
      clear();
      host.frame(1'b0, 8'h66, 24'h0, 0, 0, 0);
      host.frame(1'b0, 8'h00, 24'h0, 0, 0, 0);
      host.frame(1'b0, 8'h99, 24'h0, 0, 0, 0);
      chk({seen[4], read_params}, 9'h028);
      host.frame(1'b0, 8'h66, 24'h0, 0, 0, 0);
      @(posedge clk) write_busy <= 1'b1;
      host.frame(1'b0, 8'h99, 24'h0, 0, 0, 0);
      chk({seen[4:3], read_params}, 10'h348);
      $display("test software reset done");
      for (int k = 0; k < 4; k++)
      begin
         sec({10'h000, 2'(k), 12'h0A5}, ~4'(1 << k), 1'b0, 2'h2);
         chk({sec_prog_row, sec_prog_byte}, {2'(k), 8'hA5});
         sec({10'h000, 2'(k), 12'h0A5}, 4'(1 << k), 1'b0, 2'h1);
      end
      sec(24'h0010A5, 4'h0, 1'b1, 2'h1);
      sec(24'h0040A5, 4'h0, 1'b0, 2'h1);
      sec(24'h0110A5, 4'h0, 1'b0, 2'h1);
      $display("test security rows done");
      hwr(10, 10'h048);
      @(posedge clk) dedicated_reset_disable <= 1'b1;
      hwr(20, 10'h048);
      @(posedge clk);
      reset_pin_shared <= 1'b1;
      pause_or_reset_select <= 1'b1;
      qpi_mode <= 1'b1;
      hwr(20, 10'h048);
      @(posedge clk) {qpi_mode, quad_lines_enable} <= 2'b01;
      hwr(20, 10'h048);
      @(posedge clk) quad_lines_enable <= 1'b0;
      hwr(20, 10'h300);
      host.frame(1'b0, 8'h9F, 24'h0, 0, 0, 4);
      chk(got, 32'hA51234A5);
      $display("test hardware reset done");
      conclude();
   end
endmodule : flash_id_reset_info_cmds_tb_top
